//--- pch_pkg.sv
// pch_pkg: offsets, field positions, reset values and codes of the
// configuration header slice.
// assumes: shared by pch_cfg_regs, pch_master_gate and the bench.

package pch_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses in configuration space)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_CLASS = 8'h08;
	localparam logic [7:0] OFF_LAT = 8'h0C;
	localparam logic [7:0] OFF_IOBAR = 8'h10;

	// ----------------------------------------------------------------
	// command word bit positions
	// ----------------------------------------------------------------
	localparam int CMD_IO_BIT = 0;
	localparam int CMD_MEM_BIT = 1;
	localparam int CMD_MST_BIT = 2;
	localparam int CMD_PAR_BIT = 6;
	localparam int CMD_SERR_BIT = 8;

	// ----------------------------------------------------------------
	// class word fields
	// ----------------------------------------------------------------
	localparam logic [7:0] CLASS_BASE = 8'h02;
	localparam logic [7:0] CLASS_SUB = 8'h00;

	// ----------------------------------------------------------------
	// latency word and io base word fields
	// ----------------------------------------------------------------
	localparam int LAT_TENURE_LSB = 8;
	localparam int LAT_LINE_LSB = 0;
	localparam int IOBAR_BASE_LSB = 8;
	localparam logic IOBAR_IND = 1'b1;

	// ----------------------------------------------------------------
	// hard reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_TENURE = 8'h00;
	localparam logic [7:0] RST_LINE = 8'h00;
	localparam logic [23:0] RST_IO_BASE = 24'h000000;
	localparam logic RST_CMD_BIT = 1'b0;

	// ----------------------------------------------------------------
	// bus master commands and gate states
	// ----------------------------------------------------------------
	localparam logic [3:0] BUS_MEM_READ = 4'h6;
	localparam logic [3:0] BUS_MEM_WRITE = 4'h7;

	typedef enum logic [1:0] {
		GS_IDLE = 2'b01,
		GS_BUSY = 2'b10
	} pch_gate_state_t;

	// byte-enable merge of a write into a 32-bit image
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

endpackage : pch_pkg

//--- pch_ctl_if.sv
// pch_ctl_if: master controls from the register bank to the master gate,
// and the gate's busy flag back.
// assumes: both ends on clk_i.
`timescale 1ns/1ps
`default_nettype none

interface pch_ctl_if;
	logic master_enable_bit;
	logic [7:0] bus_tenure_limit;
	logic mst_busy;

	modport regs (
		output master_enable_bit,
		output bus_tenure_limit,
		input mst_busy
	);

	modport gate (
		input master_enable_bit,
		input bus_tenure_limit,
		output mst_busy
	);
endinterface : pch_ctl_if

`default_nettype wire

//--- pch_master_gate.sv
// pch_master_gate: admits master transactions, picks the bus command and
// limits tenure by the latency timer.
// assumes: request, grant and done come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pch_master_gate (
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// controls from the register bank
	pch_ctl_if.gate ctl,
	// master engine side
	input wire logic mst_req_i,
	input wire logic mst_write_i,
	input wire logic mst_gnt_i,
	input wire logic mst_done_i,
	output logic mst_start_o,
	output logic [3:0] mst_cmd_o,
	output logic mst_stop_o
);

	typedef struct packed {
		pch_pkg::pch_gate_state_t state;
		logic [7:0] count;
		logic start;
		logic stop;
		logic [3:0] cmd;
	} pch_gate_t;

	localparam pch_gate_t GATE_RST = '{
		state: pch_pkg::GS_IDLE,
		count: 8'h00,
		start: 1'b0,
		stop: 1'b0,
		cmd: pch_pkg::BUS_MEM_READ
	};

	pch_gate_t q;
	pch_gate_t d;

	always_comb begin
		d = q;
		d.start = 1'b0;
		d.stop = 1'b0;
		unique case (q.state)
			pch_pkg::GS_IDLE: begin
				// no start at all without the enable
				if (mst_req_i && ctl.master_enable_bit) begin
					d.state = pch_pkg::GS_BUSY;
					d.start = 1'b1;
					d.count = ctl.bus_tenure_limit;
					d.cmd = mst_write_i ? pch_pkg::BUS_MEM_WRITE
						: pch_pkg::BUS_MEM_READ;
				end
			end
			pch_pkg::GS_BUSY: begin
				// enable cleared mid-burst: finish, then idle
				if (mst_done_i) begin
					d.state = pch_pkg::GS_IDLE;
				end else begin
					if (q.count != 8'h00) begin
						d.count = q.count - 8'h01;
					end
					d.stop = (q.count == 8'h00) && !mst_gnt_i;
				end
			end
			default: begin
				d = GATE_RST;
			end
		endcase
		if (soft_rst_i) begin
			d = GATE_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= GATE_RST;
		end else begin
			q <= d;
		end
	end

	assign mst_start_o = q.start;
	assign mst_cmd_o = q.cmd;
	assign mst_stop_o = q.stop;
	assign ctl.mst_busy = (q.state == pch_pkg::GS_BUSY);

endmodule : pch_master_gate

`default_nettype wire

//--- pch_cfg_regs.sv
// pch_cfg_regs: command bits, class, latency and io base words of the
// configuration header, parity and system error response, decode claims.
// assumes: config port and target events on clk_i; parity pin is external
// and pulled up, so it idles high.
`timescale 1ns/1ps
`default_nettype none

module pch_cfg_regs #(
	// arbitrary values, not tied to any real part
	parameter logic [7:0] PROG_IF_CODE = 8'h01,
	parameter logic [7:0] SILICON_REV = 8'h3C
) (
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// configuration access port
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	// target decode
	input wire logic tgt_io_req_i,
	input wire logic [31:0] tgt_io_addr_i,
	input wire logic tgt_mem_req_i,
	input wire logic tgt_mem_hit_i,
	output logic io_claim_o,
	output logic mem_claim_o,
	// parity events from the bus logic
	input wire logic tgt_data_perr_i,
	input wire logic tgt_addr_perr_i,
	// parity error pin, open drain
	input wire logic perr_n_i,
	output logic perr_n_o,
	output logic perr_oe_o,
	// system error pin, open drain
	output logic serr_n_o,
	output logic serr_oe_o,
	// master side
	input wire logic mst_req_i,
	input wire logic mst_write_i,
	input wire logic mst_gnt_i,
	input wire logic mst_done_i,
	output logic mst_start_o,
	output logic [3:0] mst_cmd_o,
	output logic mst_stop_o,
	output logic mst_perr_o,
	// decoded control levels
	output logic master_enable_o,
	output logic memory_decode_enable_o,
	output logic io_decode_enable_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic io_decode_enable;
		logic memory_decode_enable;
		logic master_enable_bit;
		logic parity_response_enable;
		logic system_error_enable;
		logic [7:0] bus_tenure_limit;
		logic [7:0] line_size_field;
		logic [23:0] io_window_base;
		logic ack;
		logic [31:0] rdata;
		logic io_claim;
		logic mem_claim;
		logic perr_drive;
		logic serr_drive;
		logic mst_perr;
		logic perr_meta;
		logic perr_sync_n;
	} pch_regs_t;

	localparam pch_regs_t REGS_RST = '{
		io_decode_enable: pch_pkg::RST_CMD_BIT,
		memory_decode_enable: pch_pkg::RST_CMD_BIT,
		master_enable_bit: pch_pkg::RST_CMD_BIT,
		parity_response_enable: pch_pkg::RST_CMD_BIT,
		system_error_enable: pch_pkg::RST_CMD_BIT,
		bus_tenure_limit: pch_pkg::RST_TENURE,
		line_size_field: pch_pkg::RST_LINE,
		io_window_base: pch_pkg::RST_IO_BASE,
		ack: 1'b0,
		rdata: 32'h00000000,
		io_claim: 1'b0,
		mem_claim: 1'b0,
		perr_drive: 1'b0,
		serr_drive: 1'b0,
		mst_perr: 1'b0,
		perr_meta: 1'b1,
		perr_sync_n: 1'b1
	};

	pch_regs_t q;
	pch_regs_t d;

	// ----------------------------------------------------------------
	// controls shared with the master gate
	// ----------------------------------------------------------------
	// busy comes back for master-side parity sampling
	pch_ctl_if ctl ();

	assign ctl.master_enable_bit = q.master_enable_bit;
	assign ctl.bus_tenure_limit = q.bus_tenure_limit;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// word select; byte address bits 1:0 are ignored
	function automatic logic word_hit(input logic [7:0] addr,
		input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction : word_hit

	// io window match on the upper address bits
	function automatic logic io_hit(input logic [31:0] addr,
		input logic [23:0] base);
		return addr[31:pch_pkg::IOBAR_BASE_LSB] == base;
	endfunction : io_hit

	// ----------------------------------------------------------------
	// read images
	// ----------------------------------------------------------------
	logic [31:0] cmd_word;
	logic [31:0] class_word;
	logic [31:0] lat_word;
	logic [31:0] iobar_word;
	logic [31:0] rd_mux;
	logic [31:0] cmd_new;
	logic [31:0] lat_new;
	logic [31:0] iobar_new;
	logic hit_cmd;
	logic hit_lat;
	logic hit_iobar;
	logic wr;
	logic take;
	logic rd_take;

	always_comb begin
		cmd_word = 32'h00000000;
		cmd_word[pch_pkg::CMD_IO_BIT] = q.io_decode_enable;
		cmd_word[pch_pkg::CMD_MEM_BIT] = q.memory_decode_enable;
		cmd_word[pch_pkg::CMD_MST_BIT] = q.master_enable_bit;
		cmd_word[pch_pkg::CMD_PAR_BIT] = q.parity_response_enable;
		cmd_word[pch_pkg::CMD_SERR_BIT] = q.system_error_enable;
	end

	// constants only, nothing writable here
	assign class_word = {pch_pkg::CLASS_BASE, pch_pkg::CLASS_SUB,
		PROG_IF_CODE, SILICON_REV};

	// self-test and reserved bits stay zero
	always_comb begin
		lat_word = 32'h00000000;
		lat_word[pch_pkg::LAT_TENURE_LSB +: 8] = q.bus_tenure_limit;
		lat_word[pch_pkg::LAT_LINE_LSB +: 8] = q.line_size_field;
	end

	// size bits and bit 1 zero, indicator one
	always_comb begin
		iobar_word = 32'h00000000;
		iobar_word[31:pch_pkg::IOBAR_BASE_LSB] = q.io_window_base;
		iobar_word[0] = pch_pkg::IOBAR_IND;
	end

	// ----------------------------------------------------------------
	// read select
	// ----------------------------------------------------------------
	always_comb begin
		if (word_hit(cfg_addr_i, pch_pkg::OFF_CMD)) begin
			rd_mux = cmd_word;
		end else if (word_hit(cfg_addr_i, pch_pkg::OFF_CLASS)) begin
			rd_mux = class_word;
		end else if (word_hit(cfg_addr_i, pch_pkg::OFF_LAT)) begin
			rd_mux = lat_word;
		end else if (word_hit(cfg_addr_i, pch_pkg::OFF_IOBAR)) begin
			rd_mux = iobar_word;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	// no access is taken while soft reset is high
	assign take = cfg_req_i && !soft_rst_i;
	assign rd_take = take && !cfg_we_i;
	assign wr = take && cfg_we_i;
	assign hit_cmd = wr && word_hit(cfg_addr_i, pch_pkg::OFF_CMD);
	assign hit_lat = wr && word_hit(cfg_addr_i, pch_pkg::OFF_LAT);
	assign hit_iobar = wr && word_hit(cfg_addr_i, pch_pkg::OFF_IOBAR);

	// ----------------------------------------------------------------
	// byte-lane merge of writes
	// ----------------------------------------------------------------
	assign cmd_new = pch_pkg::be_merge(cmd_word, cfg_wdata_i, cfg_be_i);
	assign lat_new = pch_pkg::be_merge(lat_word, cfg_wdata_i, cfg_be_i);
	assign iobar_new = pch_pkg::be_merge(iobar_word, cfg_wdata_i, cfg_be_i);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;

		// --------------------------------------------------------
		// config port answers one cycle after the request
		// --------------------------------------------------------
		d.ack = take;
		d.rdata = rd_take ? rd_mux : 32'h00000000;

		// --------------------------------------------------------
		// register writes
		// --------------------------------------------------------
		if (hit_cmd) begin
			d.io_decode_enable = cmd_new[pch_pkg::CMD_IO_BIT];
			d.memory_decode_enable = cmd_new[pch_pkg::CMD_MEM_BIT];
			d.master_enable_bit = cmd_new[pch_pkg::CMD_MST_BIT];
			d.parity_response_enable = cmd_new[pch_pkg::CMD_PAR_BIT];
			d.system_error_enable = cmd_new[pch_pkg::CMD_SERR_BIT];
		end

		// upper 16 bits of the write are dropped
		if (hit_lat) begin
			d.bus_tenure_limit = lat_new[pch_pkg::LAT_TENURE_LSB +: 8];
			// stored for read-back only
			d.line_size_field = lat_new[pch_pkg::LAT_LINE_LSB +: 8];
		end

		// low byte of the write is dropped
		if (hit_iobar) begin
			d.io_window_base = iobar_new[31:pch_pkg::IOBAR_BASE_LSB];
		end

		// --------------------------------------------------------
		// target claims, gated by the decode enables
		// --------------------------------------------------------
		d.io_claim = tgt_io_req_i && q.io_decode_enable
			&& io_hit(tgt_io_addr_i, q.io_window_base);
		d.mem_claim = tgt_mem_req_i && tgt_mem_hit_i
			&& q.memory_decode_enable;

		// --------------------------------------------------------
		// parity error pin: two-flop synchroniser
		// --------------------------------------------------------
		d.perr_meta = perr_n_i;
		d.perr_sync_n = q.perr_meta;

		// --------------------------------------------------------
		// parity reporting, all gated by parity response
		// --------------------------------------------------------
		d.perr_drive = tgt_data_perr_i && q.parity_response_enable;
		d.serr_drive = tgt_addr_perr_i && q.parity_response_enable
			&& q.system_error_enable;
		d.mst_perr = !q.perr_sync_n && q.parity_response_enable
			&& ctl.mst_busy;

		// --------------------------------------------------------
		// soft reset keeps register contents, drops activity
		// --------------------------------------------------------
		if (soft_rst_i) begin
			d.ack = 1'b0;
			d.rdata = 32'h00000000;
			d.io_claim = 1'b0;
			d.mem_claim = 1'b0;
			d.perr_drive = 1'b0;
			d.serr_drive = 1'b0;
			d.mst_perr = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= REGS_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// master gate
	// ----------------------------------------------------------------
	// gate idles on soft reset, like the pulses here
	pch_master_gate pch_master_gate_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.soft_rst_i(soft_rst_i),
		.ctl(ctl.gate),
		.mst_req_i(mst_req_i),
		.mst_write_i(mst_write_i),
		.mst_gnt_i(mst_gnt_i),
		.mst_done_i(mst_done_i),
		.mst_start_o(mst_start_o),
		.mst_cmd_o(mst_cmd_o),
		.mst_stop_o(mst_stop_o)
	);

	// ----------------------------------------------------------------
	// config port and target claims
	// ----------------------------------------------------------------
	assign cfg_ack_o = q.ack;
	assign cfg_rdata_o = q.rdata;
	assign io_claim_o = q.io_claim;
	assign mem_claim_o = q.mem_claim;

	// ----------------------------------------------------------------
	// open-drain pins: level fixed low, enable marks the drive
	// ----------------------------------------------------------------
	assign perr_n_o = 1'b0;
	assign perr_oe_o = q.perr_drive;
	assign serr_n_o = 1'b0;
	assign serr_oe_o = q.serr_drive;

	// ----------------------------------------------------------------
	// master side and control levels
	// ----------------------------------------------------------------
	assign mst_perr_o = q.mst_perr;
	assign master_enable_o = q.master_enable_bit;
	assign memory_decode_enable_o = q.memory_decode_enable;
	assign io_decode_enable_o = q.io_decode_enable;

endmodule : pch_cfg_regs

`default_nettype wire

//--- pch_cfg_regs_sva.sv
// pch_cfg_regs_sva: port-level checks of the config header slice.
// assumes: bound onto pch_cfg_regs, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module pch_cfg_regs_sva (
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// config, target and parity
	input wire logic cfg_req_i,
	input wire logic cfg_ack_o,
	input wire logic tgt_io_req_i,
	input wire logic tgt_mem_req_i,
	input wire logic tgt_mem_hit_i,
	input wire logic io_claim_o,
	input wire logic mem_claim_o,
	input wire logic tgt_data_perr_i,
	input wire logic tgt_addr_perr_i,
	input wire logic perr_n_o,
	input wire logic perr_oe_o,
	input wire logic serr_n_o,
	input wire logic serr_oe_o,
	// master side
	input wire logic mst_req_i,
	input wire logic mst_write_i,
	input wire logic mst_gnt_i,
	input wire logic mst_start_o,
	input wire logic [3:0] mst_cmd_o,
	input wire logic mst_stop_o,
	input wire logic master_enable_o,
	input wire logic memory_decode_enable_o,
	input wire logic io_decode_enable_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_ack_follows: assert property (cfg_req_i && !soft_rst_i |=> cfg_ack_o)
		else $error("config request not acked next cycle");
	a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_req_i))
		else $error("ack without a request");
	a_perr_cause: assert property (perr_oe_o |-> $past(tgt_data_perr_i))
		else $error("parity pin driven without data parity error");
	a_serr_cause: assert property (serr_oe_o |-> $past(tgt_addr_perr_i))
		else $error("system error without address parity error");
	a_mem_claim: assert property (mem_claim_o |->
		$past(tgt_mem_req_i && tgt_mem_hit_i
		&& memory_decode_enable_o))
		else $error("memory claim without enabled hit");
	a_io_claim: assert property (io_claim_o |->
		$past(tgt_io_req_i && io_decode_enable_o))
		else $error("io claim without enabled request");
	a_start_gate: assert property (mst_start_o |->
		$past(mst_req_i && master_enable_o))
		else $error("master start while disabled");
	a_cmd_plain: assert property (mst_start_o |->
		mst_cmd_o == ($past(mst_write_i) ? 4'h7 : 4'h6))
		else $error("wrong master command");
	a_stop_grant: assert property (mst_stop_o |-> $past(!mst_gnt_i))
		else $error("stop while grant held");
	a_pin_low: assert property (!perr_n_o && !serr_n_o)
		else $error("open drain pin drives high");

	c_start: cover property (mst_start_o);
	c_io: cover property (io_claim_o);
	c_serr: cover property (serr_oe_o);
endmodule : pch_cfg_regs_sva

`default_nettype wire

//--- pch_bus_model.sv
// pch_bus_model: far side of the master gate and the pulled-up parity pin.
// assumes: bench drives hold_i and perr_inj_i on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pch_bus_model (
	// clock and master handshake
	input wire logic clk_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [7:0] hold_i,
	output logic gnt_o,
	output logic done_o,
	// parity pin, pulled up
	input wire logic perr_oe_i,
	input wire logic perr_inj_i,
	output logic perr_n_o
);
	logic [7:0] cnt_q;

	initial begin
		gnt_o = 1'b0;
		done_o = 1'b0;
		cnt_q = 8'h00;
	end

	// wired low by any driver, else pull-up
	assign perr_n_o = !(perr_oe_i || perr_inj_i);

	// grant held hold_i+1 cycles, done one cycle after stop
	always @(posedge clk_i) begin
		done_o <= stop_i && !done_o;
		if (start_i) begin
			gnt_o <= 1'b1;
			cnt_q <= hold_i;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			gnt_o <= 1'b0;
		end
	end
endmodule : pch_bus_model

`default_nettype wire

//--- pch_cfg_regs_bench.sv
// pch_cfg_regs_bench: directed tests of the config header slice.
// assumes: checker bound below, bus model on the master side.
`timescale 1ns/1ps
`default_nettype none

module pch_cfg_regs_bench;
	logic clk_i, rst_i, soft_rst_i, cfg_req_i, cfg_we_i, cfg_ack_o;
	logic [7:0] cfg_addr_i;
	logic [3:0] cfg_be_i;
	logic [31:0] cfg_wdata_i, cfg_rdata_o, tgt_io_addr_i, rd;
	logic tgt_io_req_i, tgt_mem_req_i, tgt_mem_hit_i, io_claim_o;
	logic mem_claim_o, tgt_data_perr_i, tgt_addr_perr_i, perr_n_i;
	logic perr_n_o, perr_oe_o, serr_n_o, serr_oe_o, mst_req_i;
	logic mst_write_i, mst_gnt_i, mst_done_i, mst_start_o, mst_stop_o;
	logic [3:0] mst_cmd_o;
	logic mst_perr_o, master_enable_o, memory_decode_enable_o;
	logic io_decode_enable_o, perr_inj;
	logic [7:0] hold;
	int num_errors, cmp_count, n0, n1;

	pch_cfg_regs pch_cfg_regs_inst (.*);
	pch_bus_model pch_bus_model_inst (.clk_i(clk_i), .start_i(mst_start_o),
		.stop_i(mst_stop_o), .hold_i(hold), .gnt_o(mst_gnt_i),
		.done_o(mst_done_i), .perr_oe_i(perr_oe_o), .perr_inj_i(perr_inj),
		.perr_n_o(perr_n_i));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input string n, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask : chk

	task automatic fail(input string n);
		$display("[ERR] %s exp event got timeout", n);
		num_errors++;
		report_and_stop();
	endtask : fail

	task automatic cfg(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_i);
		cfg_req_i <= 1'b1;
		cfg_we_i <= we;
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		cfg_be_i <= be;
		@(posedge clk_i);
		cfg_req_i <= 1'b0;
		#1;
		chk("ack", cfg_ack_o, 1'b1);
		rd = cfg_rdata_o;
	endtask : cfg

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cfg(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		cfg(1'b0, a, 32'h00000000, 4'hF);
		chk(n, rd, e);
	endtask : rdc

	task automatic tgt(input logic [31:0] a, input logic hit,
		input logic ei, input logic em);
		@(posedge clk_i);
		tgt_io_req_i <= 1'b1;
		tgt_io_addr_i <= a;
		tgt_mem_req_i <= 1'b1;
		tgt_mem_hit_i <= hit;
		@(posedge clk_i);
		tgt_io_req_i <= 1'b0;
		tgt_mem_req_i <= 1'b0;
		#1;
		chk("io_claim", io_claim_o, ei);
		chk("mem_claim", mem_claim_o, em);
	endtask : tgt

	task automatic par(input logic ep, input logic es);
		@(posedge clk_i);
		tgt_data_perr_i <= 1'b1;
		tgt_addr_perr_i <= 1'b1;
		@(posedge clk_i);
		tgt_data_perr_i <= 1'b0;
		tgt_addr_perr_i <= 1'b0;
		#1;
		chk("perr_oe", perr_oe_o, ep);
		chk("serr_oe", serr_oe_o, es);
	endtask : par

	task automatic nostart();
		@(posedge clk_i);
		mst_req_i <= 1'b1;
		repeat (8) begin
			@(posedge clk_i);
			#1;
			chk("no_start", mst_start_o, 1'b0);
		end
		@(posedge clk_i);
		mst_req_i <= 1'b0;
	endtask : nostart

	// one transfer; n counts cycles from start to stop
	task automatic mtx(input logic w, input logic keep, output int n);
		int i;
		@(posedge clk_i);
		mst_req_i <= 1'b1;
		mst_write_i <= w;
		i = 0;
		while (mst_start_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
			i++;
			if (i > 20) fail("start");
		end
		chk("cmd", mst_cmd_o, w ? 4'h7 : 4'h6);
		@(posedge clk_i);
		mst_req_i <= keep;
		#1;
		n = 1;
		while (mst_stop_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
			n++;
			if (n > 40) fail("stop");
		end
		repeat (3) @(posedge clk_i);
	endtask : mtx

	task automatic report_and_stop();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_i, soft_rst_i, cfg_req_i, cfg_we_i, perr_inj} = 5'h10;
		{tgt_io_req_i, tgt_mem_req_i, tgt_mem_hit_i} = 3'h0;
		{tgt_data_perr_i, tgt_addr_perr_i, mst_req_i, mst_write_i} = 4'h0;
		{cfg_addr_i, cfg_be_i, cfg_wdata_i, tgt_io_addr_i} = 76'h0;
		hold = 8'h01;
		num_errors = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("class", 8'h08, {pch_pkg::CLASS_BASE, pch_pkg::CLASS_SUB,
			8'h01, 8'h3C});
		rdc("lat", 8'h0C, 32'h00000000);
		rdc("iobar", 8'h10, 32'h00000001);
		rdc("cmd", 8'h04, 32'h00000000);
		$display("test reset values done");
		wr(8'h08, 32'hFFFFFFFF);
		rdc("class_ro", 8'h08, 32'h0200013C);
		wr(8'h0C, 32'hFFFFFFFF);
		rdc("lat_ro", 8'h0C, 32'h0000FFFF);
		cfg(1'b1, 8'h0C, 32'h00000300, 4'h2);
		rdc("lat_lane", 8'h0C, 32'h000003FF);
		wr(8'h10, 32'hFFFFFFFF);
		rdc("io_ro", 8'h10, 32'hFFFFFF01);
		wr(8'h40, 32'hFFFFFFFF);
		rdc("unmapped", 8'h40, 32'h00000000);
		$display("test access kinds done");
		@(posedge clk_i);
		soft_rst_i <= 1'b1;
		@(posedge clk_i);
		soft_rst_i <= 1'b0;
		rdc("lat_soft", 8'h0C, 32'h000003FF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		rdc("lat_hard", 8'h0C, 32'h00000000);
		rdc("io_hard", 8'h10, 32'h00000001);
		$display("test resets done");
		wr(8'h10, 32'h0000AB00);
		tgt(32'h0000AB10, 1'b1, 1'b0, 1'b0);
		wr(8'h04, 32'h00000003);
		tgt(32'h0000AB10, 1'b1, 1'b1, 1'b1);
		tgt(32'h0000AC10, 1'b0, 1'b0, 1'b0);
		$display("test decode done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, {23'h0, i[1], 1'b0, i[0], 6'h00});
			par(i[0], i[0] & i[1]);
		end
		$display("test parity done");
		wr(8'h04, 32'h00000000);
		nostart();
		wr(8'h0C, 32'h00000500);
		wr(8'h04, 32'h00000044);
		mtx(1'b1, 1'b0, n0);
		chk("tenure", n0, 32'd6);
		wr(8'h0C, 32'h000005FF);
		mtx(1'b0, 1'b0, n1);
		chk("line_size", n1, 32'd6);
		@(posedge clk_i);
		hold <= 8'h10;
		fork
			mtx(1'b0, 1'b1, n1);
			begin
				repeat (4) @(posedge clk_i);
				perr_inj <= 1'b1;
				repeat (4) @(posedge clk_i);
				#1;
				chk("mst_perr", mst_perr_o, 1'b1);
				@(posedge clk_i);
				perr_inj <= 1'b0;
				wr(8'h04, 32'h00000040);
			end
		join
		chk("tenure_gnt", n1, 32'd19);
		nostart();
		$display("test master done");
		report_and_stop();
	end
endmodule : pch_cfg_regs_bench

bind pch_cfg_regs pch_cfg_regs_sva pch_cfg_regs_sva_inst (.*);

`default_nettype wire
